// ---- src/swg_top.sv ----
/*
 * swg_top: sfr write guard register, device control register, page index and
 * the six guarded sfrs they protect.
 * assumes the cpu gives one-cycle wr/rd strobes and reports the reset cause.
 */
`timescale 1ns/1ps
module swg_top (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    // cause of the current reset: high for por, lvr, pin or enabled bor
    input  wire logic                hard_reset_in,
    // cpu sfr bus
    input  wire swg_pkg::swg_sfr_req_t sfr_req_in,
    output logic               [7:0] sfr_rdata_out,
    output logic                     sfr_hit_out,
    // device control
    output swg_pkg::swg_devctl_t     devctl_out,
    output logic                     iap_exec_allow_out,
    output logic                     ext_reset_route_out,
    output logic                     port4_pin7_gpio_out,
    output logic                     debug_on_port4_out,
    output logic               [3:0] sfr_page_index_out,
    // guarded register values
    output logic               [7:0] port_six_register_out,
    output logic               [7:0] port_four_register_out,
    output logic               [7:0] watchdog_control_out,
    output logic               [7:0] clock_control_zero_out,
    output logic               [7:0] power_control_one_out,
    output logic               [7:0] power_control_zero_out
);

    typedef struct packed {
        logic [7:0] guard;
        logic [7:0] devctl;
        logic [3:0] page;
    } swg_top_st_t;

    swg_top_st_t st_r;
    swg_top_st_t st_nxt;

    logic wr_p;
    logic [7:0] port6_q;
    logic [7:0] port4_q;
    logic [7:0] wdt_q;
    logic [7:0] clk0_q;
    logic [7:0] pwr1_q;
    logic [7:0] pwr0_q;
    logic       port6_hold;

    // address match for a write strobe
    function automatic logic wr_hit(input swg_pkg::swg_sfr_req_t r, input logic [11:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction : wr_hit

    assign wr_p = sfr_req_in.wr && sfr_req_in.page_p;

    // page-p-only registers; reserved bits masked so stray ones never store
    always_comb begin
        st_nxt = st_r;
        if (wr_p && (sfr_req_in.addr == swg_pkg::SWG_GUARD_ADDR)) begin
            st_nxt.guard = sfr_req_in.wdata & swg_pkg::SWG_GUARD_MASK;
        end
        if (wr_p && (sfr_req_in.addr == swg_pkg::SWG_DEVCTL_ADDR)) begin
            st_nxt.devctl = sfr_req_in.wdata & swg_pkg::SWG_DEVCTL_MASK;
        end
        // page index is reachable from every page
        if (wr_hit(sfr_req_in, swg_pkg::SWG_PAGEIDX_ADDR)) begin
            st_nxt.page = sfr_req_in.wdata[3:0];
        end
    end

    // one synchronous reset for the page-p registers and page index; no reset-cause exemptions here
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_r.guard  <= swg_pkg::SWG_GUARD_RST;
            st_r.devctl <= swg_pkg::SWG_DEVCTL_RST;
            st_r.page   <= swg_pkg::SWG_PAGE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // port 6 survives only the first edge of a soft reset when the scope bit is set; that edge clears the scope bit
    assign port6_hold = st_r.devctl[swg_pkg::SWG_D_IOR] && !hard_reset_in;

    // port 6: the only guarded register whose reset depends on the reset cause
    swg_guarded_reg #(.RST_VAL(swg_pkg::SWG_PORT_RST)) u_port6 (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .hold_rst_in (port6_hold),
        .sel_in      (wr_hit(sfr_req_in, swg_pkg::SWG_PORT6_ADDR)),
        .page_p_in   (sfr_req_in.page_p),
        .guard_in    (st_r.guard[swg_pkg::SWG_G_PORT6]),
        .wdata_in    (sfr_req_in.wdata),
        .q_out       (port6_q)
    );

    // port 4: pad muxing lives elsewhere, this is only the latch
    swg_guarded_reg #(.RST_VAL(swg_pkg::SWG_PORT_RST)) u_port4 (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .hold_rst_in (1'b0),
        .sel_in      (wr_hit(sfr_req_in, swg_pkg::SWG_PORT4_ADDR)),
        .page_p_in   (sfr_req_in.page_p),
        .guard_in    (st_r.guard[swg_pkg::SWG_G_PORT4]),
        .wdata_in    (sfr_req_in.wdata),
        .q_out       (port4_q)
    );

    // watchdog control: guarded so stray code cannot quietly disarm the watchdog
    swg_guarded_reg #(.RST_VAL(swg_pkg::SWG_ZERO_RST)) u_wdt (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .hold_rst_in (1'b0),
        .sel_in      (wr_hit(sfr_req_in, swg_pkg::SWG_WDT_ADDR)),
        .page_p_in   (sfr_req_in.page_p),
        .guard_in    (st_r.guard[swg_pkg::SWG_G_WDT]),
        .wdata_in    (sfr_req_in.wdata),
        .q_out       (wdt_q)
    );

    // clock control 0
    swg_guarded_reg #(.RST_VAL(swg_pkg::SWG_ZERO_RST)) u_clk0 (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .hold_rst_in (1'b0),
        .sel_in      (wr_hit(sfr_req_in, swg_pkg::SWG_CLK0_ADDR)),
        .page_p_in   (sfr_req_in.page_p),
        .guard_in    (st_r.guard[swg_pkg::SWG_G_CLK0]),
        .wdata_in    (sfr_req_in.wdata),
        .q_out       (clk0_q)
    );

    // power control 1
    swg_guarded_reg #(.RST_VAL(swg_pkg::SWG_ZERO_RST)) u_pwr1 (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .hold_rst_in (1'b0),
        .sel_in      (wr_hit(sfr_req_in, swg_pkg::SWG_PWR1_ADDR)),
        .page_p_in   (sfr_req_in.page_p),
        .guard_in    (st_r.guard[swg_pkg::SWG_G_PWR1]),
        .wdata_in    (sfr_req_in.wdata),
        .q_out       (pwr1_q)
    );

    // power control 0: its reset value differs from the other power register
    swg_guarded_reg #(.RST_VAL(swg_pkg::SWG_PWR0_RST)) u_pwr0 (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .hold_rst_in (1'b0),
        .sel_in      (wr_hit(sfr_req_in, swg_pkg::SWG_PWR0_ADDR)),
        .page_p_in   (sfr_req_in.page_p),
        .guard_in    (st_r.guard[swg_pkg::SWG_G_PWR0]),
        .wdata_in    (sfr_req_in.wdata),
        .q_out       (pwr0_q)
    );

    // read mux: guarded registers answer on every page regardless of guard
    always_comb begin
        sfr_rdata_out = 8'h00;
        sfr_hit_out   = 1'b1;
        case (sfr_req_in.addr)
            swg_pkg::SWG_PORT6_ADDR:   sfr_rdata_out = port6_q;
            swg_pkg::SWG_PORT4_ADDR:   sfr_rdata_out = port4_q;
            swg_pkg::SWG_WDT_ADDR:     sfr_rdata_out = wdt_q;
            swg_pkg::SWG_CLK0_ADDR:    sfr_rdata_out = clk0_q;
            swg_pkg::SWG_PWR1_ADDR:    sfr_rdata_out = pwr1_q;
            swg_pkg::SWG_PWR0_ADDR:    sfr_rdata_out = pwr0_q;
            swg_pkg::SWG_PAGEIDX_ADDR: sfr_rdata_out = {4'h0, st_r.page};
            swg_pkg::SWG_GUARD_ADDR: begin
                sfr_rdata_out = st_r.guard;
                sfr_hit_out   = sfr_req_in.page_p;
            end
            swg_pkg::SWG_DEVCTL_ADDR: begin
                sfr_rdata_out = st_r.devctl;
                sfr_hit_out   = sfr_req_in.page_p;
            end
            default: sfr_hit_out = 1'b0;
        endcase
        if (!sfr_hit_out) begin
            sfr_rdata_out = 8'h00;
        end
    end

    // decoded device controls; speed bits only steer circuits, software sequences them
    always_comb begin
        devctl_out.high_speed_enable    = st_r.devctl[swg_pkg::SWG_D_HSE];
        devctl_out.ultra_speed_enable   = st_r.devctl[swg_pkg::SWG_D_ULTRA_SPEED_ENABLE];
        devctl_out.iap_region_no_exec   = st_r.devctl[swg_pkg::SWG_D_IAP_REGION_NO_EXEC];
        devctl_out.port_six_reset_scope = st_r.devctl[swg_pkg::SWG_D_IOR];
        devctl_out.reset_pin_select     = st_r.devctl[swg_pkg::SWG_D_RESET_PIN_SELECT];
        devctl_out.debug_port_enable    = st_r.devctl[swg_pkg::SWG_D_DEBUG_PORT_ENABLE];
    end

    assign iap_exec_allow_out  = !st_r.devctl[swg_pkg::SWG_D_IAP_REGION_NO_EXEC];
    assign ext_reset_route_out = st_r.devctl[swg_pkg::SWG_D_RESET_PIN_SELECT];
    assign port4_pin7_gpio_out = !st_r.devctl[swg_pkg::SWG_D_RESET_PIN_SELECT];
    assign debug_on_port4_out  = st_r.devctl[swg_pkg::SWG_D_DEBUG_PORT_ENABLE];
    assign sfr_page_index_out  = st_r.page;

    assign port_six_register_out  = port6_q;
    assign port_four_register_out = port4_q;
    assign watchdog_control_out   = wdt_q;
    assign clock_control_zero_out = clk0_q;
    assign power_control_one_out  = pwr1_q;
    assign power_control_zero_out = pwr0_q;

endmodule : swg_top

// ---- src/swg_pkg.sv ----
/*
 * swg_pkg: constants and carriers for the sfr write guard and device control block.
 * assumes a cpu-side sfr bus with page-p selection decoded by the core.
 */
package swg_pkg;

    // page-p sfr offsets
    localparam logic [11:0] SWG_GUARD_ADDR  = 12'h488;
    localparam logic [11:0] SWG_DEVCTL_ADDR = 12'h04c;
    // ordinary-page offsets of guarded registers and the page index (page-p aliases use the same address)
    localparam logic [11:0] SWG_PORT6_ADDR  = 12'h0f8;
    localparam logic [11:0] SWG_PORT4_ADDR  = 12'h0e8;
    localparam logic [11:0] SWG_WDT_ADDR    = 12'h0e1;
    localparam logic [11:0] SWG_CLK0_ADDR   = 12'h0c7;
    localparam logic [11:0] SWG_PWR1_ADDR   = 12'h097;
    localparam logic [11:0] SWG_PWR0_ADDR   = 12'h087;
    localparam logic [11:0] SWG_PAGEIDX_ADDR = 12'h0ac;

    // guard bit positions
    localparam int SWG_G_PORT6 = 6;
    localparam int SWG_G_PORT4 = 5;
    localparam int SWG_G_WDT   = 4;
    localparam int SWG_G_CLK0  = 2;
    localparam int SWG_G_PWR1  = 1;
    localparam int SWG_G_PWR0  = 0;

    // device control bit positions
    localparam int SWG_D_HSE   = 7;
    localparam int SWG_D_IAP_REGION_NO_EXEC  = 6;
    localparam int SWG_D_ULTRA_SPEED_ENABLE  = 5;
    localparam int SWG_D_IOR   = 2;
    localparam int SWG_D_RESET_PIN_SELECT = 1;
    localparam int SWG_D_DEBUG_PORT_ENABLE  = 0;

    // reset values and writable masks
    localparam logic [7:0] SWG_GUARD_RST   = 8'h00;
    localparam logic [7:0] SWG_GUARD_MASK  = 8'h77;
    localparam logic [7:0] SWG_DEVCTL_RST  = 8'h83;
    localparam logic [7:0] SWG_DEVCTL_MASK = 8'he7;
    localparam logic [3:0] SWG_PAGE_RST    = 4'h0;
    localparam logic [7:0] SWG_PORT_RST    = 8'hff;
    localparam logic [7:0] SWG_ZERO_RST    = 8'h00;
    localparam logic [7:0] SWG_PWR0_RST    = 8'h10;

    // cpu sfr bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        page_p;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } swg_sfr_req_t;

    // decoded device control outputs
    typedef struct packed {
        logic high_speed_enable;
        logic ultra_speed_enable;
        logic iap_region_no_exec;
        logic port_six_reset_scope;
        logic reset_pin_select;
        logic debug_port_enable;
    } swg_devctl_t;

endpackage : swg_pkg

// ---- src/swg_guarded_reg.sv ----
/*
 * swg_guarded_reg: one 8-bit sfr held behind a write guard bit.
 * assumes the parent decodes address and page; reset value fixed per instance.
 */
`timescale 1ns/1ps
module swg_guarded_reg #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       hold_rst_in,
    // write request
    input  wire logic       sel_in,
    input  wire logic       page_p_in,
    input  wire logic       guard_in,
    input  wire logic [7:0] wdata_in,
    // stored value
    output logic      [7:0] q_out
);

    typedef struct packed {
        logic [7:0] val;
    } swg_greg_st_t;

    swg_greg_st_t st_r;
    swg_greg_st_t st_nxt;

    // a blocked write is simply dropped, nothing is flagged
    always_comb begin
        st_nxt = st_r;
        if (sel_in && (page_p_in || !guard_in)) begin
            st_nxt.val = wdata_in;
        end
    end

    // hold_rst_in lets a caller exempt this register from a reset event
    always_ff @(posedge clk_in) begin
        if (!rst_n_in && !hold_rst_in) begin
            st_r.val <= RST_VAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_out = st_r.val;

endmodule : swg_guarded_reg

// ---- tb/swg_top_sva.sv ----
/*
 * swg_top_sva: concurrent checks on the ports of swg_top.
 * assumes binding from the bench top; tracks a shadow of the guard register.
 */
`timescale 1ns/1ps
module swg_top_sva (
    // clock, reset and bus
    input wire logic                   clk_in, rst_n_in, hard_reset_in,
    input wire swg_pkg::swg_sfr_req_t  sfr_req_in,
    // observed outputs
    input wire logic [7:0]             sfr_rdata_out, port_six_register_out,
    input wire logic [7:0]             port_four_register_out, watchdog_control_out,
    input wire logic [7:0]             clock_control_zero_out, power_control_one_out,
    input wire logic [7:0]             power_control_zero_out,
    input wire swg_pkg::swg_devctl_t   devctl_out,
    input wire logic                   iap_exec_allow_out, ext_reset_route_out,
    input wire logic                   port4_pin7_gpio_out, debug_on_port4_out,
    input wire logic [3:0]             sfr_page_index_out
);
    logic [7:0]  g_r;
    logic [11:0] a;
    logic [3:0]  wd4;
    logic        wo;
    logic        wp;
    // short aliases: wo is a write outside page p, wp one inside it
    assign a   = sfr_req_in.addr;
    assign wd4 = sfr_req_in.wdata[3:0];
    assign wo  = sfr_req_in.wr & ~sfr_req_in.page_p;
    assign wp  = sfr_req_in.wr & sfr_req_in.page_p;
    // shadow of the guard, since the checker cannot see the register itself
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            g_r <= 8'h00;
        end else if (wp && a == swg_pkg::SWG_GUARD_ADDR) begin
            g_r <= sfr_req_in.wdata & swg_pkg::SWG_GUARD_MASK;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_P6_HOLD: assert property (
        wo && a == swg_pkg::SWG_PORT6_ADDR && g_r[6] |=> $stable(port_six_register_out))
        else $error("port six changed on a guarded write");
    AST_P4_HOLD: assert property (
        wo && a == swg_pkg::SWG_PORT4_ADDR && g_r[5] |=> $stable(port_four_register_out))
        else $error("port four changed on a guarded write");
    AST_WDT_HOLD: assert property (
        wo && a == swg_pkg::SWG_WDT_ADDR && g_r[4] |=> $stable(watchdog_control_out))
        else $error("watchdog control changed on a guarded write");
    AST_CLK0_HOLD: assert property (
        wo && a == swg_pkg::SWG_CLK0_ADDR && g_r[swg_pkg::SWG_G_CLK0]
        |=> $stable(clock_control_zero_out))
        else $error("clock control zero changed on a guarded write");
    AST_PWR1_HOLD: assert property (
        wo && a == swg_pkg::SWG_PWR1_ADDR && g_r[swg_pkg::SWG_G_PWR1]
        |=> $stable(power_control_one_out))
        else $error("power control one changed on a guarded write");
    AST_PWR0_HOLD: assert property (
        wo && a == swg_pkg::SWG_PWR0_ADDR && g_r[swg_pkg::SWG_G_PWR0]
        |=> $stable(power_control_zero_out))
        else $error("power control zero changed on a guarded write");
    AST_PAGEP_WR: assert property (
        wp && a == swg_pkg::SWG_PORT4_ADDR |=> port_four_register_out == $past(sfr_req_in.wdata))
        else $error("page p write to port four lost");
    AST_RD_P6: assert property (
        a == swg_pkg::SWG_PORT6_ADDR |-> sfr_rdata_out == port_six_register_out)
        else $error("port six read data wrong");
    AST_IAP: assert property (
        iap_exec_allow_out == !devctl_out.iap_region_no_exec)
        else $error("iap execute permission wrong");
    AST_PIN: assert property (
        ext_reset_route_out == devctl_out.reset_pin_select
        && port4_pin7_gpio_out != ext_reset_route_out)
        else $error("reset pad routing wrong");
    AST_DBG: assert property (
        debug_on_port4_out == devctl_out.debug_port_enable)
        else $error("debug routing wrong");
    AST_IDX: assert property (
        sfr_req_in.wr && a == swg_pkg::SWG_PAGEIDX_ADDR |=> sfr_page_index_out == $past(wd4))
        else $error("page index not written");
    AST_P6_KEEP: assert property (disable iff (1'b0)
        !rst_n_in && !hard_reset_in && devctl_out.port_six_reset_scope
        |=> $stable(port_six_register_out)) else $error("port six cleared by a soft reset");
    AST_P6_CLR: assert property (disable iff (1'b0)
        !rst_n_in && (hard_reset_in || !devctl_out.port_six_reset_scope)
        |=> port_six_register_out == 8'hff) else $error("port six not reset");
    // main scenarios reached
    cover property (wo && g_r != 8'h00);
    cover property (wp && a == swg_pkg::SWG_PORT6_ADDR);
    cover property (!rst_n_in && devctl_out.port_six_reset_scope);
endmodule : swg_top_sva

// ---- tb/tb_swg_top.sv ----
/*
 * tb_swg_top: directed bench for swg_top.
 * assumes the checker swg_top_sva is compiled alongside; drives ports directly.
 */
`timescale 1ns/1ps
module tb_swg_top;
    logic                  clk_in = 1'b0;
    logic                  rst_n_in = 1'b0;
    logic                  hard_reset_in = 1'b1;
    swg_pkg::swg_sfr_req_t req = '0;
    swg_pkg::swg_devctl_t  dc;
    logic [7:0]            rdata, p6;
    logic                  iap_ok, ext_rst, gpio7, dbg, hit;
    logic [3:0]            pidx;
    int                    fail_count = 0;
    int                    samples_checked = 0;
    // 100 mhz clock
    always #5 clk_in = ~clk_in;
    swg_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .hard_reset_in(hard_reset_in),
        .sfr_req_in(req), .sfr_rdata_out(rdata), .sfr_hit_out(hit), .devctl_out(dc),
        .iap_exec_allow_out(iap_ok), .ext_reset_route_out(ext_rst),
        .port4_pin7_gpio_out(gpio7), .debug_on_port4_out(dbg), .sfr_page_index_out(pidx),
        .port_six_register_out(p6), .port_four_register_out(), .watchdog_control_out(),
        .clock_control_zero_out(), .power_control_one_out(), .power_control_zero_out());
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one write strobe, released at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic pp, input logic [7:0] d);
        @(posedge clk_in);
        req <= '{wr: 1'b1, rd: 1'b0, page_p: pp, addr: a, wdata: d};
        @(posedge clk_in);
        req <= '0;
    endtask : wr
    // read data is combinational, so look half a cycle later
    task automatic rd(input logic [11:0] a, input logic pp, input logic [7:0] exp);
        @(posedge clk_in);
        req <= '{wr: 1'b0, rd: 1'b1, page_p: pp, addr: a, wdata: 8'h00};
        @(negedge clk_in);
        check(rdata, exp);
    endtask : rd
    // single-edge reset so the scope bit is still seen at that edge
    task automatic pulse_rst(input logic hard);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        hard_reset_in <= hard;
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
    endtask : pulse_rst
    task automatic t_reset_vals;
        @(negedge clk_in);
        check({2'h0, dc}, 8'h23);
        rd(swg_pkg::SWG_GUARD_ADDR, 1'b1, 8'h00);
        rd(swg_pkg::SWG_PWR0_ADDR, 1'b0, 8'h10);
    endtask : t_reset_vals
    task automatic t_guards;
        logic [11:0] ga [6];
        int          gb [6];
        logic [7:0]  gr [6];
        ga = '{swg_pkg::SWG_PORT6_ADDR, swg_pkg::SWG_PORT4_ADDR, swg_pkg::SWG_WDT_ADDR,
               swg_pkg::SWG_CLK0_ADDR, swg_pkg::SWG_PWR1_ADDR, swg_pkg::SWG_PWR0_ADDR};
        gb = '{6, 5, 4, 2, 1, 0};
        gr = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h10};
        // own bit blocks, the other five bits must not
        for (int i = 0; i < 6; i++) begin
            wr(swg_pkg::SWG_GUARD_ADDR, 1'b1, 8'h01 << gb[i]);
            wr(ga[i], 1'b0, 8'h3c);
            rd(ga[i], 1'b0, gr[i]);
            wr(ga[i], 1'b1, 8'ha5);
            rd(ga[i], 1'b0, 8'ha5);
            wr(swg_pkg::SWG_GUARD_ADDR, 1'b1, 8'h77 ^ (8'h01 << gb[i]));
            wr(ga[i], 1'b0, 8'h5a);
            rd(ga[i], 1'b0, 8'h5a);
        end
    endtask : t_guards
    task automatic t_devctl;
        wr(swg_pkg::SWG_GUARD_ADDR, 1'b1, 8'h77);
        rd(swg_pkg::SWG_GUARD_ADDR, 1'b1, 8'h77);
        // page-p-only registers ignore and hide ordinary-page accesses
        wr(swg_pkg::SWG_GUARD_ADDR, 1'b0, 8'h00);
        rd(swg_pkg::SWG_GUARD_ADDR, 1'b1, 8'h77);
        rd(swg_pkg::SWG_GUARD_ADDR, 1'b0, 8'h00);
        check({7'h00, hit}, 8'h00);
        rd(swg_pkg::SWG_PORT6_ADDR, 1'b0, 8'h5a);
        check({7'h00, hit}, 8'h01);
        wr(swg_pkg::SWG_DEVCTL_ADDR, 1'b1, 8'he7);
        rd(swg_pkg::SWG_DEVCTL_ADDR, 1'b1, 8'he7);
        wr(swg_pkg::SWG_DEVCTL_ADDR, 1'b0, 8'h00);
        rd(swg_pkg::SWG_DEVCTL_ADDR, 1'b1, 8'he7);
        check({2'h0, dc}, 8'h3f);
        check({5'h00, iap_ok, gpio7, dbg}, 8'h01);
        wr(swg_pkg::SWG_DEVCTL_ADDR, 1'b1, 8'h00);
        @(negedge clk_in);
        check({4'h0, iap_ok, gpio7, dbg, ext_rst}, 8'h0c);
    endtask : t_devctl
    task automatic t_page;
        wr(swg_pkg::SWG_PAGEIDX_ADDR, 1'b0, 8'h0f);
        @(negedge clk_in);
        check({4'h0, pidx}, 8'h0f);
    endtask : t_page
    task automatic t_scope;
        wr(swg_pkg::SWG_PORT6_ADDR, 1'b1, 8'h5a);
        wr(swg_pkg::SWG_DEVCTL_ADDR, 1'b1, 8'h04);
        pulse_rst(1'b0);
        check(p6, 8'h5a);
        pulse_rst(1'b0);
        check(p6, 8'hff);
        wr(swg_pkg::SWG_PORT6_ADDR, 1'b1, 8'h5a);
        wr(swg_pkg::SWG_DEVCTL_ADDR, 1'b1, 8'h04);
        pulse_rst(1'b1);
        check(p6, 8'hff);
    endtask : t_scope
    task automatic final_report;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        hard_reset_in <= 1'b0;
        t_reset_vals();
        t_guards();
        t_devctl();
        t_page();
        t_scope();
        final_report();
    end
endmodule : tb_swg_top
bind swg_top swg_top_sva i_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .hard_reset_in(hard_reset_in), .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out),
    .port_six_register_out(port_six_register_out), .devctl_out(devctl_out),
    .port_four_register_out(port_four_register_out),
    .watchdog_control_out(watchdog_control_out), .iap_exec_allow_out(iap_exec_allow_out),
    .clock_control_zero_out(clock_control_zero_out),
    .power_control_one_out(power_control_one_out),
    .power_control_zero_out(power_control_zero_out),
    .ext_reset_route_out(ext_reset_route_out), .port4_pin7_gpio_out(port4_pin7_gpio_out),
    .debug_on_port4_out(debug_on_port4_out), .sfr_page_index_out(sfr_page_index_out));
